//--- cfe_regs.vh
/*
 Flag register layout, operation class codes, condition codes and reset values of the flag unit.
 Assumes it is included by bare name from the flag unit files.
*/
`ifndef CFE_REGS_VH
`define CFE_REGS_VH
`define CFE_FLAGS_ADDR   8'hE7
`define CFE_FLAGS_RESET  8'h00
`define CFE_BIT_C        7
`define CFE_BIT_Z        6
`define CFE_BIT_S        5
`define CFE_BIT_V        4
`define CFE_BIT_D        3
`define CFE_BIT_H        2
`define CFE_BIT_USER     1
`define CFE_BIT_SPACE    0
`define CFE_RP_RESET     8'h00
`define CFE_OP_NONE      5'h00
`define CFE_OP_ADD       5'h01
`define CFE_OP_ADC       5'h02
`define CFE_OP_SUB       5'h03
`define CFE_OP_SBC       5'h04
`define CFE_OP_AND       5'h05
`define CFE_OP_OR        5'h06
`define CFE_OP_XOR       5'h07
`define CFE_OP_TM        5'h08
`define CFE_OP_TCM       5'h09
`define CFE_OP_SLA       5'h0A
`define CFE_OP_SRA       5'h0B
`define CFE_OP_RRC       5'h0C
`define CFE_OP_RLC       5'h0D
`define CFE_OP_STACK     5'h0E
`define CFE_OP_DIV       5'h0F
`define CFE_OP_STEPPED_WORD_DIVIDE     5'h10
`define CFE_OP_CPJF      5'h11
`define CFE_OP_CPJT      5'h12
`define CFE_OP_DECREMENT_BRANCH_NONZERO      5'h13
`define CFE_OP_BIT_BRANCH_FALSE      5'h14
`define CFE_OP_BIT_BRANCH_TRUE      5'h15
`define CFE_OP_JPCC      5'h16
`define CFE_OP_WFI       5'h17
`define CFE_OP_HALT      5'h18
`define CFE_OP_SRPL      5'h19
`define CFE_OP_SET_WINDOW_POINTER_LOW      5'h1A
`define CFE_OP_SET_WINDOW_POINTER_HIGH      5'h1B
`define CFE_OP_INTERRUPT_RETURN      5'h1C
`define CFE_OP_SCF       5'h1D
`define CFE_OP_RCF       5'h1E
`define CFE_OP_CCF       5'h1F
`define CFE_CC_F         4'h0
`define CFE_CC_T         4'h8
`define CFE_CC_C         4'h7
`define CFE_CC_NC        4'hF
`define CFE_CC_Z         4'h6
`define CFE_CC_NZ        4'hE
`define CFE_CC_MI        4'h5
`define CFE_CC_PL        4'hD
`define CFE_CC_V         4'h4
`define CFE_CC_NV        4'hC
`define CFE_CC_LT        4'h1
`define CFE_CC_GE        4'h9
`define CFE_CC_LE        4'h2
`define CFE_CC_GT        4'hA
`define CFE_CC_ULE       4'h3
`define CFE_CC_UGT       4'hB
`endif

//--- cfe_cond.v
/*
 Condition code evaluator for conditional branches.
 Assumes flags come from the flag register of the same clock domain.
*/
`timescale 1ns/1ps
`include "cfe_regs.vh"
module cfe_cond (
  // Condition select and flags
  input  wire [3:0] cc,
  input  wire       fc,
  input  wire       fz,
  input  wire       fs,
  input  wire       fv,
  // Result
  output reg        taken
);
  always @* begin
    case (cc)
      `CFE_CC_F:   taken = 1'b0; // RULE23
      `CFE_CC_T:   taken = 1'b1; // RULE23
      `CFE_CC_C:   taken = fc; // RULE19
      `CFE_CC_NC:  taken = ~fc;
      `CFE_CC_Z:   taken = fz;
      `CFE_CC_NZ:  taken = ~fz;
      `CFE_CC_MI:  taken = fs;
      `CFE_CC_PL:  taken = ~fs;
      `CFE_CC_V:   taken = fv;
      `CFE_CC_NV:  taken = ~fv;
      `CFE_CC_LT:  taken = fs ^ fv; // RULE20
      `CFE_CC_GE:  taken = ~(fs ^ fv); // RULE20
      `CFE_CC_LE:  taken = fz | (fs ^ fv); // RULE20
      `CFE_CC_GT:  taken = ~(fz | (fs ^ fv)); // RULE20
      `CFE_CC_ULE: taken = fc | fz; // RULE20
      `CFE_CC_UGT: taken = ~(fc | fz); // RULE20
      default:     taken = 1'b0;
    endcase
  end
endmodule // cfe_cond

//--- cfe_flags.v
/*
 Flag unit of the core: flag register, working register pointers, branch decisions,
 wait and halt states, and the program/data space pin.
 Assumes the sequencer presents one operation per op_valid pulse with its ALU results
 already computed; undefined flag results are held unchanged here.
*/
`timescale 1ns/1ps
`include "cfe_regs.vh"
// Operation
// RULE1 - Byte add sets CZSVH, clears D
// RULE2 - Byte subtract sets CZSVH, sets D
// RULE3 - Logic ops keep C, set ZS, clear V
// RULE4 - Mask tests set ZS only, clear V
// RULE5 - Left shift sets CZSV; byte clears D
// RULE6 - Right shift flags differ byte versus word
// RULE7 - Rotates through carry set CSV, byte Z
// RULE8 - Stack operations leave every flag unchanged
// RULE9 - Byte divide sets C, D; ZS updated
// RULE10 - Compare branch alters no flags
// RULE11 - Decrement branch if nonzero, no flags
// RULE12 - Bit test branch leaves flags unchanged
// RULE13 - Wait stops until interrupt; DMA serviced
// RULE14 - Halt stops until reset only
// RULE15 - Long pointer sixteen; short pointers eight each
// RULE16 - Flags held at register location 231
// RULE17 - Bit 1 is untouched user bit
// RULE18 - Bit 0 selects space, drives pin
// RULE19 - Conditions use only C Z S V
// RULE20 - Signed uses S xor V; unsigned C
// RULE21 - Memory accesses follow selector bit
// RULE22 - Interrupt return restores flags; carry ops
// RULE23 - False never branches, true always branches
module cfe_flags (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_b,
  // Operation request
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire        op_word,
  input  wire [3:0]  op_cc,
  input  wire [7:0]  op_arg,
  // ALU results for the operation
  input  wire        res_c,
  input  wire        res_z,
  input  wire        res_s,
  input  wire        res_v,
  input  wire        res_h,
  input  wire        cmp_true,
  input  wire        bit_val,
  input  wire [15:0] dec_val,
  // Saved context for interrupt return
  input  wire [7:0]  saved_flags,
  // Register file access to location 231
  input  wire        rf_wr,
  input  wire        rf_rd,
  input  wire [7:0]  rf_addr,
  input  wire [7:0]  rf_wdata,
  output reg  [7:0]  rf_rdata,
  // Memory space select from the sequencer
  input  wire        sel_prog,
  input  wire        sel_data,
  // Events
  input  wire        irq_enabled,
  input  wire        dma_req,
  input  wire        dma_done,
  // Results
  output reg  [7:0]  flags,
  output reg         branch,
  output reg         post_incr,
  output reg  [15:0] dec_out,
  output reg  [7:0]  rp0,
  output reg  [7:0]  rp1,
  output reg         run_stop,
  output reg         halted,
  output reg         dma_active,
  output reg         mem_space,
  output reg         pd_pin
);

  localparam ST_RUN  = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_DMA  = 2'b10;
  localparam ST_HALT = 2'b11;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [7:0]  next_flags;
  reg         next_branch;
  reg         next_post_incr;
  reg  [15:0] next_dec;
  wire        cc_taken;
  wire [15:0] dec_res;
  wire        dec_nz;
  wire        do_op;
  wire        rf_hit;
  wire        rf_write;

  assign do_op   = op_valid & (state == ST_RUN);
  assign rf_hit  = (rf_addr == `CFE_FLAGS_ADDR);
  assign rf_write = rf_wr & rf_hit;
  assign dec_res = op_word ? (dec_val - 16'h0001) : {8'h00, dec_val[7:0] - 8'h01};
  assign dec_nz  = (dec_res != 16'h0000);

  // Accepted operation of one class; inputs passed in so always @* sees them
  function op_is;
    input       ok;
    input [4:0] code;
    input [4:0] want;
    begin
      op_is = ok && (code == want);
    end
  endfunction

  // Eight-register window base, kept aligned so short windows never straddle
  function [7:0] win8;
    input [7:0] arg;
    begin
      win8 = {arg[7:3], 3'h0};
    end
  endfunction

  cfe_cond u_cond (
    .cc    (op_cc),
    .fc    (flags[`CFE_BIT_C]),
    .fz    (flags[`CFE_BIT_Z]),
    .fs    (flags[`CFE_BIT_S]),
    .fv    (flags[`CFE_BIT_V]),
    .taken (cc_taken)
  );

  // Flag effects; undefined results keep the old value to stay deterministic
  always @* begin
    next_flags     = flags;
    next_branch    = 1'b0;
    next_post_incr = 1'b0;
    next_dec       = dec_out;
    if (rf_write) begin
      next_flags = rf_wdata; // RULE16
    end
    if (do_op) begin
      case (op_code)
        `CFE_OP_ADD, `CFE_OP_ADC: begin
          next_flags[`CFE_BIT_C] = res_c; // RULE1
          next_flags[`CFE_BIT_Z] = res_z;
          next_flags[`CFE_BIT_S] = res_s;
          next_flags[`CFE_BIT_V] = res_v;
          if (!op_word) begin
            next_flags[`CFE_BIT_D] = 1'b0; // RULE1
            next_flags[`CFE_BIT_H] = res_h;
          end
        end
        `CFE_OP_SUB, `CFE_OP_SBC: begin
          next_flags[`CFE_BIT_C] = res_c; // RULE2
          next_flags[`CFE_BIT_Z] = res_z;
          next_flags[`CFE_BIT_S] = res_s;
          next_flags[`CFE_BIT_V] = res_v;
          if (!op_word) begin
            next_flags[`CFE_BIT_D] = 1'b1; // RULE2
            next_flags[`CFE_BIT_H] = res_h;
          end
        end
        `CFE_OP_AND, `CFE_OP_OR, `CFE_OP_XOR: begin
          next_flags[`CFE_BIT_Z] = res_z; // RULE3
          next_flags[`CFE_BIT_S] = res_s;
          next_flags[`CFE_BIT_V] = 1'b0; // RULE3
        end
        `CFE_OP_TM, `CFE_OP_TCM: begin
          next_flags[`CFE_BIT_Z] = res_z; // RULE4
          next_flags[`CFE_BIT_S] = res_s;
          next_flags[`CFE_BIT_V] = 1'b0; // RULE4
        end
        `CFE_OP_SLA: begin
          next_flags[`CFE_BIT_C] = res_c; // RULE5
          next_flags[`CFE_BIT_Z] = res_z;
          next_flags[`CFE_BIT_S] = res_s;
          next_flags[`CFE_BIT_V] = res_v;
          if (!op_word) begin
            next_flags[`CFE_BIT_D] = 1'b0; // RULE5
            next_flags[`CFE_BIT_H] = res_h;
          end
        end
        `CFE_OP_SRA: begin
          next_flags[`CFE_BIT_C] = res_c; // RULE6
          next_flags[`CFE_BIT_S] = res_s;
          if (op_word) begin
            next_flags[`CFE_BIT_V] = 1'b0; // RULE6
          end else begin
            next_flags[`CFE_BIT_Z] = res_z; // RULE6
            next_flags[`CFE_BIT_V] = res_v;
            next_flags[`CFE_BIT_D] = 1'b0;
            next_flags[`CFE_BIT_H] = res_h;
          end
        end
        `CFE_OP_RRC, `CFE_OP_RLC: begin
          next_flags[`CFE_BIT_C] = res_c; // RULE7
          next_flags[`CFE_BIT_S] = res_s;
          next_flags[`CFE_BIT_V] = res_v;
          if (!op_word) begin
            next_flags[`CFE_BIT_Z] = res_z; // RULE7
          end
        end
        `CFE_OP_STACK: begin
          next_flags = flags; // RULE8
        end
        `CFE_OP_DIV: begin
          next_flags[`CFE_BIT_C] = 1'b1; // RULE9
          next_flags[`CFE_BIT_D] = 1'b1; // RULE9
          next_flags[`CFE_BIT_Z] = res_z;
          next_flags[`CFE_BIT_S] = res_s;
        end
        `CFE_OP_STEPPED_WORD_DIVIDE: begin
          next_flags = flags; // RULE9
        end
        `CFE_OP_CPJF: begin
          next_branch    = ~cmp_true; // RULE10
          next_post_incr = cmp_true; // RULE10
        end
        `CFE_OP_CPJT: begin
          next_branch    = cmp_true; // RULE10
          next_post_incr = ~cmp_true; // RULE10
        end
        `CFE_OP_DECREMENT_BRANCH_NONZERO: begin
          next_dec    = dec_res; // RULE11
          next_branch = dec_nz; // RULE11
        end
        `CFE_OP_BIT_BRANCH_FALSE: begin
          next_branch = ~bit_val; // RULE12
        end
        `CFE_OP_BIT_BRANCH_TRUE: begin
          next_branch = bit_val; // RULE12
        end
        `CFE_OP_JPCC: begin
          next_branch = cc_taken; // RULE19
        end
        `CFE_OP_INTERRUPT_RETURN: begin
          next_flags[7:2] = saved_flags[7:2]; // RULE22
        end
        `CFE_OP_SCF: begin
          next_flags[`CFE_BIT_C] = 1'b1; // RULE22
        end
        `CFE_OP_RCF: begin
          next_flags[`CFE_BIT_C] = 1'b0; // RULE22
        end
        `CFE_OP_CCF: begin
          next_flags[`CFE_BIT_C] = ~flags[`CFE_BIT_C]; // RULE22
        end
        default: begin
          next_flags = next_flags;
        end
      endcase
      // User bit is never an instruction flag effect
      next_flags[`CFE_BIT_USER] = rf_write ? rf_wdata[`CFE_BIT_USER]
                                           : flags[`CFE_BIT_USER]; // RULE17
    end
    // Hardware space selection wins over software writes to bit 0
    if (sel_prog) begin
      next_flags[`CFE_BIT_SPACE] = 1'b0; // RULE18
    end else if (sel_data) begin
      next_flags[`CFE_BIT_SPACE] = 1'b1; // RULE18
    end
  end

  // Wait and halt sequencing
  always @* begin
    case (state)
      ST_RUN: begin
        if (op_is(do_op, op_code, `CFE_OP_HALT)) begin
          next_state = ST_HALT; // RULE14
        end else if (op_is(do_op, op_code, `CFE_OP_WFI)) begin
          next_state = ST_WAIT; // RULE13
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (irq_enabled) begin
          next_state = ST_RUN; // RULE13
        end else if (dma_req) begin
          next_state = ST_DMA; // RULE13
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_DMA: begin
        next_state = dma_done ? ST_WAIT : ST_DMA; // RULE13
      end
      ST_HALT: begin
        next_state = ST_HALT; // RULE14
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      state      <= ST_RUN;
      flags      <= `CFE_FLAGS_RESET;
      branch     <= 1'b0;
      post_incr  <= 1'b0;
      dec_out    <= 16'h0000;
      rp0        <= `CFE_RP_RESET;
      rp1        <= `CFE_RP_RESET;
      run_stop   <= 1'b0;
      halted     <= 1'b0;
      dma_active <= 1'b0;
      mem_space  <= 1'b0;
      pd_pin     <= 1'b0;
      rf_rdata   <= 8'h00;
    end else begin
      state      <= next_state;
      flags      <= next_flags;
      branch     <= next_branch;
      post_incr  <= next_post_incr;
      dec_out    <= next_dec;
      run_stop   <= (next_state != ST_RUN); // RULE13
      halted     <= (next_state == ST_HALT); // RULE14
      dma_active <= (next_state == ST_DMA);
      mem_space  <= next_flags[`CFE_BIT_SPACE]; // RULE21
      pd_pin     <= next_flags[`CFE_BIT_SPACE]; // RULE18
      rf_rdata   <= (rf_rd && rf_hit) ? flags : 8'h00; // RULE16
      if (do_op) begin
        case (op_code)
          `CFE_OP_SRPL: begin
            rp0 <= {op_arg[7:4], 4'h0}; // RULE15
            rp1 <= {op_arg[7:4], 4'h8}; // RULE15
          end
          `CFE_OP_SET_WINDOW_POINTER_LOW: begin
            rp0 <= win8(op_arg); // RULE15
          end
          `CFE_OP_SET_WINDOW_POINTER_HIGH: begin
            rp1 <= win8(op_arg); // RULE15
          end
          default: begin
            rp0 <= rp0;
          end
        endcase
      end
    end
  end
endmodule // cfe_flags

//--- cfe_flags_props.sv
/*
 Checker for the flag unit: flag effects, branch decisions, wait and halt, space pin.
 Assumes it is bound to cfe_flags and sees only its ports.
*/
`timescale 1ns/1ps
`include "cfe_regs.vh"
module cfe_flags_props (
  // Clock and reset
  input wire       mclk,
  input wire       rst_b,
  // Operation
  input wire       op_valid,
  input wire [4:0] op_code,
  input wire       op_word,
  input wire [3:0] op_cc,
  input wire       res_c,
  input wire       res_z,
  input wire       res_h,
  input wire       rf_wr,
  input wire       sel_prog,
  input wire       sel_data,
  // Results
  input wire [7:0] flags,
  input wire       branch,
  input wire       run_stop,
  input wire       halted,
  input wire       mem_space,
  input wire       pd_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Register writes and space selects also touch flags, so keep them out
  wire quiet = !rf_wr && !sel_prog && !sel_data;
  wire go    = op_valid && !run_stop && quiet;
  property p_add;
    go && !op_word && (op_code == `CFE_OP_ADD || op_code == `CFE_OP_ADC) |=>
      flags[7] == $past(res_c) && flags[6] == $past(res_z) && flags[3:2] == {1'b0, $past(res_h)};
  endproperty
  a_add: assert property (p_add) else $error("byte add flags wrong");
  property p_sub;
    go && !op_word && (op_code == `CFE_OP_SUB || op_code == `CFE_OP_SBC) |=> flags[3];
  endproperty
  a_sub: assert property (p_sub) else $error("byte subtract decimal flag wrong");
  property p_logic;
    go && op_code inside {`CFE_OP_AND, `CFE_OP_OR, `CFE_OP_XOR, `CFE_OP_TM, `CFE_OP_TCM} |=>
      flags[7] == $past(flags[7]) && !flags[4] && flags[6] == $past(res_z);
  endproperty
  a_logic: assert property (p_logic) else $error("logic flags wrong");
  property p_still;
    go && op_code inside {`CFE_OP_STACK, `CFE_OP_CPJF, `CFE_OP_CPJT, `CFE_OP_DECREMENT_BRANCH_NONZERO,
      `CFE_OP_BIT_BRANCH_FALSE, `CFE_OP_BIT_BRANCH_TRUE, `CFE_OP_JPCC} |=> $stable(flags);
  endproperty
  a_still: assert property (p_still) else $error("flags moved");
  property p_div;
    go && !op_word && op_code == `CFE_OP_DIV |=> flags[7] && flags[3];
  endproperty
  a_div: assert property (p_div) else $error("divide flags wrong");
  property p_wait;
    run_stop && quiet |=> $stable(flags);
  endproperty
  a_wait: assert property (p_wait) else $error("flags moved while stopped");
  property p_halt;
    halted |=> halted && run_stop;
  endproperty
  a_halt: assert property (p_halt) else $error("halt left without reset");
  property p_pin;
    pd_pin == flags[0] && mem_space == flags[0];
  endproperty
  a_pin: assert property (p_pin) else $error("space pin differs");
  property p_fixed_cc;
    go && op_code == `CFE_OP_JPCC && op_cc[2:0] == 3'h0 |=> branch == $past(op_cc[3]);
  endproperty
  a_fixed_cc: assert property (p_fixed_cc) else $error("fixed condition wrong");
  c_add: cover property (go && op_code == `CFE_OP_ADD);
  c_wait: cover property (run_stop && !halted);
  c_halt: cover property (halted);
endmodule // cfe_flags_props
bind cfe_flags cfe_flags_props u_props (.mclk, .rst_b, .op_valid, .op_code, .op_word, .op_cc,
  .res_c, .res_z, .res_h, .rf_wr, .sel_prog, .sel_data, .flags, .branch, .run_stop, .halted,
  .mem_space, .pd_pin);

//--- cfe_flags_bench.sv
/*
 Self-checking bench for the flag unit with a bit-level model of the flags.
 Assumes the flag unit alone, one 50 MHz clock, inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`include "cfe_regs.vh"
module cfe_flags_bench;
  reg         mclk, rst_b, op_valid, op_word, cmp_true, bit_val, rf_wr, rf_rd, eb, ep;
  reg         res_c, res_z, res_s, res_v, res_h, sel_prog, sel_data, irq_enabled, dma_req;
  reg         dma_done;
  reg  [4:0]  op_code;
  reg  [3:0]  op_cc;
  reg  [7:0]  op_arg, saved_flags, rf_addr, rf_wdata, m, erp0, erp1;
  reg  [15:0] dec_val, edec;
  wire [7:0]  rf_rdata, flags, rp0, rp1;
  wire [15:0] dec_out;
  wire        branch, post_incr, run_stop, halted, dma_active, mem_space, pd_pin;
  integer     seed, fails, num_checks, i, k;
  cfe_flags dut (.mclk, .rst_b, .op_valid, .op_code, .op_word, .op_cc, .op_arg, .res_c, .res_z,
    .res_s, .res_v, .res_h, .cmp_true, .bit_val, .dec_val, .saved_flags, .rf_wr, .rf_rd,
    .rf_addr, .rf_wdata, .rf_rdata, .sel_prog, .sel_data, .irq_enabled, .dma_req, .dma_done,
    .flags, .branch, .post_incr, .dec_out, .rp0, .rp1, .run_stop, .halted, .dma_active,
    .mem_space, .pd_pin);
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  task chk(input string nm, input [15:0] s, input [15:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("ERROR %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Flags before the op decide the branch; cc bit 3 inverts the base test
  function cond(input [3:0] cc);
    reg [7:0] t;
    t = {m[7], m[6], m[5], m[4], m[7] | m[6], m[6] | (m[5] ^ m[4]), m[5] ^ m[4], 1'b0};
    cond = t[cc[2:0]] ^ cc[3];
  endfunction
  task op(input [4:0] c, input w, input [3:0] cc);
    {res_c, res_z, res_s, res_v, res_h, cmp_true, bit_val} = $random(seed);
    dec_val = $random(seed);
    op_arg = $random(seed);
    saved_flags = $random(seed);
    {op_valid, op_code, op_word, op_cc} = {1'b1, c, w, cc};
    {eb, ep} = 2'b00;
    case (c)
      `CFE_OP_ADD, `CFE_OP_ADC, `CFE_OP_SLA, `CFE_OP_SUB, `CFE_OP_SBC: begin
        m[7:4] = {res_c, res_z, res_s, res_v};
        if (!w) m[3:2] = {c == `CFE_OP_SUB || c == `CFE_OP_SBC, res_h};
      end
      `CFE_OP_SRA: if (!w) m[7:2] = {res_c, res_z, res_s, res_v, 1'b0, res_h};
        else {m[7], m[5], m[4]} = {res_c, res_s, 1'b0};
      `CFE_OP_AND, `CFE_OP_OR, `CFE_OP_XOR, `CFE_OP_TM, `CFE_OP_TCM:
        m[6:4] = {res_z, res_s, 1'b0};
      `CFE_OP_RRC, `CFE_OP_RLC: begin
        {m[7], m[5], m[4]} = {res_c, res_s, res_v};
        if (!w) m[6] = res_z;
      end
      `CFE_OP_DIV: if (!w) {m[7:5], m[3]} = {1'b1, res_z, res_s, 1'b1};
      `CFE_OP_INTERRUPT_RETURN: m[7:2] = saved_flags[7:2];
      `CFE_OP_SCF: m[7] = 1'b1;
      `CFE_OP_RCF: m[7] = 1'b0;
      `CFE_OP_CCF: m[7] = !m[7];
      `CFE_OP_CPJF: {eb, ep} = {!cmp_true, cmp_true};
      `CFE_OP_CPJT: {eb, ep} = {cmp_true, !cmp_true};
      `CFE_OP_BIT_BRANCH_FALSE: eb = !bit_val;
      `CFE_OP_BIT_BRANCH_TRUE: eb = bit_val;
      `CFE_OP_DECREMENT_BRANCH_NONZERO: begin
        edec = w ? dec_val - 16'h0001 : {8'h00, dec_val[7:0] - 8'h01};
        eb = edec != 16'h0000;
      end
      `CFE_OP_JPCC: eb = cond(cc);
      `CFE_OP_SRPL: {erp0, erp1} = {op_arg[7:4], 4'h0, op_arg[7:4], 4'h8};
      `CFE_OP_SET_WINDOW_POINTER_LOW: erp0 = {op_arg[7:3], 3'h0};
      `CFE_OP_SET_WINDOW_POINTER_HIGH: erp1 = {op_arg[7:3], 3'h0};
      default: ;
    endcase
    @(negedge mclk);
    chk("flags", flags, m);
    chk("branch", branch, eb);
    chk("post_incr", post_incr, ep);
    chk("dec_out", dec_out, edec);
    chk("pointers", {rp0, rp1}, {erp0, erp1});
  endtask
  task reg_io(input wr, input [7:0] a, input [7:0] v);
    {rf_wr, rf_rd, rf_addr, rf_wdata} = {wr, !wr, a, v};
    @(negedge mclk);
    // Strobes stay up; the next access or the caller lowers them once
    if (wr && a == `CFE_FLAGS_ADDR) m = v;
    if (!wr) chk("rf_rdata", rf_rdata, a == `CFE_FLAGS_ADDR ? m : 8'h00);
  endtask
  task space(input [1:0] v);
    {sel_prog, sel_data} = v;
    @(negedge mclk);
    m[0] = !v[1];
    chk("pd_pin", {pd_pin, mem_space}, {2{m[0]}});
  endtask
  initial begin
    #100000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    seed = 32'hbd9f;
    {fails, num_checks, m, erp0, erp1, edec, rst_b} = 0;
    {op_valid, op_word, cmp_true, bit_val, rf_wr, rf_rd, res_c, res_z, res_s, res_v} = 0;
    {res_h, sel_prog, sel_data, irq_enabled, dma_req, dma_done, op_code, op_cc} = 0;
    {op_arg, saved_flags, rf_addr, rf_wdata, dec_val} = 0;
    repeat (3) @(negedge mclk);
    rst_b = 1;
    chk("flags", flags, `CFE_FLAGS_RESET);
    for (i = 0; i < 300; i = i + 1) begin
      k = $random(seed);
      if (k[4:0] == `CFE_OP_WFI || k[4:0] == `CFE_OP_HALT) k = 0;
      op(k[4:0], k[4:0] != `CFE_OP_DIV && k[5], k[9:6]);
    end
    op_valid = 0;
    // Every condition code against fresh flags; bit 0 kept since hardware owns it
    for (i = 0; i < 32; i = i + 1) begin
      k = $random(seed);
      reg_io(1, `CFE_FLAGS_ADDR, {k[7:1], m[0]});
      reg_io(0, `CFE_FLAGS_ADDR, 8'h00);
      op(`CFE_OP_JPCC, 0, i[3:0]);
    end
    reg_io(1, 8'hE6, 8'h5A);
    reg_io(0, 8'hE6, 8'h00);
    {rf_wr, rf_rd} = 2'b00;
    space(2'b01);
    space(2'b10);
    space(2'b01);
    space(2'b11);
    {sel_prog, sel_data} = 2'b00;
    op(`CFE_OP_WFI, 0, 0);
    op_code = `CFE_OP_ADD;
    @(negedge mclk);
    chk("run_stop", {run_stop, flags}, {1'b1, m});
    dma_req = 1;
    @(negedge mclk);
    {op_valid, dma_req} = 2'b00;
    chk("dma_active", dma_active, 1);
    dma_done = 1;
    @(negedge mclk);
    dma_done = 0;
    chk("dma_wait", {dma_active, run_stop}, 2'b01);
    irq_enabled = 1;
    @(negedge mclk);
    irq_enabled = 0;
    chk("run_stop", run_stop, 0);
    op(`CFE_OP_HALT, 0, 0);
    {op_valid, irq_enabled} = 2'b01;
    repeat (3) @(negedge mclk);
    chk("halted", {halted, run_stop}, 2'b11);
    {irq_enabled, rst_b} = 2'b00;
    @(negedge mclk);
    rst_b = 1;
    chk("halted", {halted, flags}, {1'b0, `CFE_FLAGS_RESET});
    give_verdict;
  end
endmodule // cfe_flags_bench
